// File: core/issue_sched_defs.vh
`ifndef ISSUE_SCHED_DEFS_VH
`define ISSUE_SCHED_DEFS_VH
// operation classes on the decode port
`define OP_ALU      3'h0
`define OP_ALUX     3'h1
`define OP_MUL      3'h2
`define OP_LOAD     3'h3
`define OP_STORE    3'h4
`define OP_LIMM     3'h5
// multiply expands into this many x operations
`define MUL_PARTS   2'h3
// y operand wait above this many cycles bumps to x
`define BUMP_WAIT   2'h1
// load data latency, address to result
`define LOAD_LAT    2'h2
// slots presented per cycle
`define SLOTS       6
`endif

// File: core/dual_pipe_issue_scheduler.v
// Behaviour
// - multiply busy: register ops only to Y
// - multiply: two decode cycles, three x parts
// - one load issued per cycle
// - shifts only X, wait for multiply
// - load-immediate uses no unit, result ready
// - y op waiting over one cycle rehomed X
// - next ready op takes Y behind bumped
// - one operation per Y per cycle
// - stages decode, issue, fetch, execute in order
// - up to six operations per cycle
// - load result with execute two, one clock after execute one
// - dependent load repeats operand fetch
`timescale 1ns/100ps
`include "issue_sched_defs.vh"
module dual_pipe_issue_scheduler #(
    parameter SLOTS = `SLOTS
) (
    input  wire                 clk,
    input  wire                 srst,
    input  wire [SLOTS-1:0]     opValid,
    input  wire [3*SLOTS-1:0]   opClass,
    input  wire [2*SLOTS-1:0]   opWait,
    input  wire [SLOTS-1:0]     opDepLoad,
    output reg  [SLOTS-1:0]     opTaken,
    output reg                  decodeHold,
    output reg                  xIssue,
    output reg  [2:0]           xSlot,
    output reg  [1:0]           xMulPart,
    output reg                  yIssue,
    output reg  [2:0]           ySlot,
    output reg                  loadIssue,
    output reg  [2:0]           loadSlot,
    output reg                  storeIssue,
    output reg  [2:0]           storeSlot,
    output reg  [SLOTS-1:0]     limmDone,
    output reg                  yBump,
    output reg                  xFetch,
    output reg                  xExecOne,
    output reg                  xExecTwo,
    output reg                  yFetch,
    output reg                  yExecOne,
    output reg                  loadFetch,
    output reg                  loadExecOne,
    output reg                  loadExecTwo,
    output reg                  loadResult,
    output reg                  storeFetch,
    output reg                  storeExecOne,
    output reg                  storeExecTwo
);
    localparam MS_IDLE = 3'h1;
    localparam MS_DEC2 = 3'h2;
    localparam MS_RUN  = 3'h4;

    reg  [2:0]       mulState_q;
    reg  [1:0]       mulLeft_q;
    reg  [2:0]       mulSlot_q;
    reg              loadRep_q;
    reg              bumpGo;
    reg              xNew;
    reg  [1:0]       bumpWait_q;
    reg              yFetch_q;
    reg  [1:0]       yWait_q;
    reg              loadFetch_q;
    reg              loadDep_q;
    reg              lastLoadBusy_q;
    reg  [SLOTS-1:0] taken_d;
    reg              xUsed;
    reg              yUsed;
    reg              lUsed;
    reg              sUsed;
    reg  [2:0]       cls;
    reg  [1:0]       wt;
    reg  [2:0]       xSlot_d;
    reg  [2:0]       ySlot_d;
    reg  [2:0]       lSlot_d;
    reg  [2:0]       sSlot_d;
    reg              mulStart;
    reg              bumpNow;
    reg              loadStall;
    wire             mulBusy;
    integer          i;

    assign mulBusy = (mulState_q != MS_IDLE);

    // scan in program order: lowest slot is oldest
    always @* begin
        taken_d   = {SLOTS{1'b0}};
        // pending bumped ops reserve x; they wait out multiply parts
        bumpGo    = (bumpWait_q != 2'h0) & (mulState_q != MS_RUN);
        xUsed     = mulBusy | (bumpWait_q != 2'h0);
        xNew      = 1'b0;
        cls       = 3'h0;
        wt        = 2'h0;
        yUsed     = 1'b0;
        lUsed     = 1'b0;
        sUsed     = 1'b0;
        xSlot_d   = 3'h0;
        ySlot_d   = 3'h0;
        lSlot_d   = 3'h0;
        sSlot_d   = 3'h0;
        mulStart  = 1'b0;
        loadStall = loadFetch_q & loadDep_q & lastLoadBusy_q;
        for (i = 0; i < SLOTS; i = i + 1) begin
            cls = opClass[3*i +: 3];
            wt  = opWait[2*i +: 2];
            if (opValid[i]) begin
                case (cls)
                    `OP_LIMM: begin
                        taken_d[i] = 1'b1;
                    end
                    `OP_MUL, `OP_ALUX: begin
                        if (!xUsed) begin
                            xUsed      = 1'b1;
                            taken_d[i] = 1'b1;
                            xSlot_d    = i[2:0];
                            xNew       = 1'b1;
                            mulStart   = (cls == `OP_MUL);
                        end
                    end
                    `OP_ALU: begin
                        if (!yUsed) begin
                            yUsed      = 1'b1;
                            taken_d[i] = 1'b1;
                            ySlot_d    = i[2:0];
                        end else if (!xUsed && wt <= `BUMP_WAIT) begin
                            xUsed      = 1'b1;
                            xNew       = 1'b1;
                            taken_d[i] = 1'b1;
                            xSlot_d    = i[2:0];
                        end
                    end
                    `OP_LOAD: begin
                        if (!lUsed && !loadStall) begin
                            lUsed      = 1'b1;
                            taken_d[i] = 1'b1;
                            lSlot_d    = i[2:0];
                        end
                    end
                    `OP_STORE: begin
                        if (!sUsed) begin
                            sUsed      = 1'b1;
                            taken_d[i] = 1'b1;
                            sSlot_d    = i[2:0];
                        end
                    end
                    default: begin
                        taken_d[i] = 1'b0;
                    end
                endcase
            end
        end
        // in-order: nothing taken behind an untaken op
        for (i = 1; i < SLOTS; i = i + 1) begin
            if (opValid[i-1] && !taken_d[i-1]) begin
                taken_d[i] = 1'b0;
            end
        end
        // a grant masked by the in-order pass is no issue
        xNew     = xNew & taken_d[xSlot_d];
        mulStart = mulStart & taken_d[xSlot_d];
        yUsed    = yUsed & taken_d[ySlot_d];
        lUsed    = lUsed & taken_d[lSlot_d];
        sUsed    = sUsed & taken_d[sSlot_d];
        bumpNow = yFetch_q & (yWait_q > `BUMP_WAIT);
    end

    always @(posedge clk) begin
        if (srst) begin
            mulState_q     <= MS_IDLE;
            mulLeft_q      <= 2'h0;
            mulSlot_q      <= 3'h0;
            loadRep_q      <= 1'b0;
            bumpWait_q     <= 2'h0;
            yFetch_q       <= 1'b0;
            yWait_q        <= 2'h0;
            loadFetch_q    <= 1'b0;
            loadDep_q      <= 1'b0;
            lastLoadBusy_q <= 1'b0;
            opTaken        <= {SLOTS{1'b0}};
            decodeHold     <= 1'b0;
            xIssue         <= 1'b0;
            xSlot          <= 3'h0;
            xMulPart       <= 2'h0;
            yIssue         <= 1'b0;
            ySlot          <= 3'h0;
            loadIssue      <= 1'b0;
            loadSlot       <= 3'h0;
            storeIssue     <= 1'b0;
            storeSlot      <= 3'h0;
            limmDone       <= {SLOTS{1'b0}};
            yBump          <= 1'b0;
            xFetch         <= 1'b0;
            xExecOne       <= 1'b0;
            xExecTwo       <= 1'b0;
            yFetch         <= 1'b0;
            yExecOne       <= 1'b0;
            loadFetch      <= 1'b0;
            loadExecOne    <= 1'b0;
            loadExecTwo    <= 1'b0;
            loadResult     <= 1'b0;
            storeFetch     <= 1'b0;
            storeExecOne   <= 1'b0;
            storeExecTwo   <= 1'b0;
        end else begin
            decodeHold <= 1'b0;
            xMulPart   <= 2'h0;
            case (mulState_q)
                MS_IDLE: begin
                    if (mulStart) begin
                        mulState_q <= MS_DEC2;
                        mulSlot_q  <= xSlot_d;
                        decodeHold <= 1'b1;
                    end
                end
                MS_DEC2: begin
                    mulState_q <= MS_RUN;
                    mulLeft_q  <= `MUL_PARTS;
                end
                MS_RUN: begin
                    xMulPart  <= `MUL_PARTS - mulLeft_q + 2'h1;
                    mulLeft_q <= mulLeft_q - 2'h1;
                    if (mulLeft_q == 2'h1) begin
                        mulState_q <= MS_IDLE;
                    end
                end
                default: begin
                    mulState_q <= MS_IDLE;
                end
            endcase
            opTaken  <= taken_d & {SLOTS{~decodeHold}};
            for (i = 0; i < SLOTS; i = i + 1) begin
                limmDone[i] <= taken_d[i] & (opClass[3*i +: 3] == `OP_LIMM);
            end
            // bumped op re-enters X the next cycle unless multiply parts are running, Y free for followers
            bumpWait_q <= bumpWait_q + {1'b0, bumpNow} - {1'b0, bumpGo};
            // multiply issues only its three parts
            xIssue   <= (xNew & ~mulStart) | bumpGo | (mulState_q == MS_RUN);
            xSlot    <= (mulState_q == MS_RUN) ? mulSlot_q : xSlot_d;
            yIssue   <= yUsed;
            ySlot    <= ySlot_d;
            yFetch_q <= yUsed;
            yWait_q  <= yUsed ? opWait[2*ySlot_d +: 2] : 2'h0;
            yBump    <= bumpNow;
            loadIssue   <= lUsed;
            loadSlot    <= lSlot_d;
            loadFetch_q <= lUsed | loadStall;
            loadDep_q   <= loadStall | (lUsed & opDepLoad[lSlot_d]);
            lastLoadBusy_q <= loadFetch_q & ~loadStall;
            storeIssue  <= sUsed;
            storeSlot   <= sSlot_d;
            // stage chain per unit
            xFetch       <= xIssue;
            xExecOne     <= xFetch;
            xExecTwo     <= xExecOne & (xMulPart != 2'h0);
            yFetch       <= yIssue;
            yExecOne     <= yFetch & ~bumpNow;
            loadFetch    <= loadIssue | loadStall;
            loadRep_q    <= loadStall;
            loadExecOne  <= loadFetch & ~loadRep_q;
            loadExecTwo  <= loadExecOne;
            loadResult   <= loadExecOne;
            storeFetch   <= storeIssue;
            storeExecOne <= storeFetch;
            storeExecTwo <= storeExecOne;
        end
    end
endmodule

// File: tb/issue_sched_sva.sv
`timescale 1ns/100ps
`include "issue_sched_defs.vh"
module issue_sched_sva #(
    parameter SLOTS = 6
) (
    input wire logic               clk,
    input wire logic               srst,
    input wire logic [3*SLOTS-1:0] opClass,
    input wire logic [SLOTS-1:0]   opTaken,
    input wire logic               decodeHold,
    input wire logic               xIssue,
    input wire logic [1:0]         xMulPart,
    input wire logic               xFetch,
    input wire logic               yIssue,
    input wire logic               yFetch,
    input wire logic               yBump,
    input wire logic               loadIssue,
    input wire logic               loadFetch,
    input wire logic               loadExecOne,
    input wire logic               loadExecTwo,
    input wire logic               loadResult
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    function automatic int loads(input logic [SLOTS-1:0] t, input logic [3*SLOTS-1:0] c);
        loads = 0;
        for (int i = 0; i < SLOTS; i++)
            loads += (t[i] && c[3*i+:3] == `OP_LOAD);
    endfunction
    sequence s_mulParts;
        xIssue && xMulPart == 2'h1 ##1 xIssue && xMulPart == 2'h2 ##1 xIssue && xMulPart == 2'h3;
    endsequence
    sequence s_loadTail;
        loadExecTwo && loadResult;
    endsequence
    property p_mulParts; decodeHold |-> ##2 s_mulParts; endproperty
    property p_loadTail; loadExecOne |=> s_loadTail; endproperty
    property p_loadFetch; loadIssue |=> loadFetch; endproperty
    property p_xFetch; xIssue && xMulPart == 2'h0 |=> xFetch; endproperty
    property p_yFetch; yIssue |=> yFetch; endproperty
    property p_bump; yBump |=> xIssue; endproperty
    property p_inOrder; ((opTaken + 1'b1) & opTaken) == '0; endproperty
    property p_oneLoad; loads(opTaken, $past(opClass)) <= 1; endproperty
    a_mulParts: assert property (p_mulParts) else $error("multiply parts out of step");
    a_loadTail: assert property (p_loadTail) else $error("load result late");
    a_loadFetch: assert property (p_loadFetch) else $error("load fetch missing");
    a_xFetch: assert property (p_xFetch) else $error("x fetch missing");
    a_yFetch: assert property (p_yFetch) else $error("y fetch missing");
    a_bump: assert property (p_bump) else $error("bumped op not reissued");
    a_inOrder: assert property (p_inOrder) else $error("ops taken out of order");
    a_oneLoad: assert property (p_oneLoad) else $error("two loads taken");
endmodule
bind dual_pipe_issue_scheduler issue_sched_sva #(.SLOTS(SLOTS)) checker_i (.clk, .srst, .opClass, .opTaken,
    .decodeHold, .xIssue, .xMulPart, .xFetch, .yIssue, .yFetch, .yBump, .loadIssue, .loadFetch,
    .loadExecOne, .loadExecTwo, .loadResult);

// File: tb/op_feeder.sv
`timescale 1ns/100ps
module op_feeder (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [5:0]  opTaken,
    output logic      [5:0]  opValid,
    output logic      [17:0] opClass,
    output logic      [11:0] opWait,
    output logic      [5:0]  opDepLoad
);
    logic [5:0] q[$];
    logic       shown = 1'b0;
    initial {opValid, opClass, opWait, opDepLoad} = 42'h0;
    task automatic push(input logic [5:0] op);
        q.push_back(op);
    endtask
    // present one cycle, then retire what was taken and offer the rest again
    always @(posedge clk) begin
        #1;
        if (srst || shown) begin
            if (!srst)
                repeat ($countones(opTaken)) void'(q.pop_front());
            opValid = 6'h0;
            {opDepLoad, opWait, opClass} = ~{opDepLoad, opWait, opClass};
            shown = 1'b0;
        end else if (q.size() != 0) begin
            for (int i = 0; i < 6; i++) begin
                opValid[i] = i < q.size();
                if (i < q.size())
                    {opDepLoad[i], opWait[2*i+:2], opClass[3*i+:3]} = q[i];
            end
            shown = 1'b1;
        end
    end
endmodule

// File: tb/dual_pipe_issue_scheduler_tb_top.sv
`timescale 1ns/100ps
`include "issue_sched_defs.vh"
module dual_pipe_issue_scheduler_tb_top;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [5:0]  opValid, opTaken, opDepLoad, limmDone;
    logic [17:0] opClass;
    logic [11:0] opWait;
    logic [1:0]  xMulPart;
    logic        decodeHold, xIssue, yIssue, yBump, loadIssue, loadResult, storeIssue, storeExecTwo;
    logic [31:0] rs = 32'hfa58;
    logic [5:0]  ops[$];
    int          errorCnt = 0;
    int          comparisons = 0;
    int          nIss, nLoad, nStore, nLimm, nPart, nHold;
    always #20 clk = ~clk;
    op_feeder feed (.clk, .srst, .opTaken, .opValid, .opClass, .opWait, .opDepLoad);
    dual_pipe_issue_scheduler dut (.clk, .srst, .opValid, .opClass, .opWait, .opDepLoad, .opTaken,
        .decodeHold, .xIssue, .xSlot(), .xMulPart, .yIssue, .ySlot(), .loadIssue, .loadSlot(),
        .storeIssue, .storeSlot(), .limmDone, .yBump, .xFetch(), .xExecOne(), .xExecTwo(), .yFetch(),
        .yExecOne(), .loadFetch(), .loadExecOne(), .loadExecTwo(), .loadResult, .storeFetch(),
        .storeExecOne(), .storeExecTwo);
    always @(posedge clk) begin
        nIss += xIssue + yIssue + loadIssue + storeIssue - yBump;
        nLoad += loadResult;
        nStore += storeExecTwo;
        nLimm += $countones(limmDone);
        nPart += (xIssue && xMulPart != 2'h0);
        nHold += decodeHold;
    end
    function automatic logic [31:0] nextRand();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    function automatic logic [5:0] op(input logic [2:0] c, input logic [1:0] w, input logic d);
        return {d, w, c};
    endfunction
    function automatic int expOf(input logic [2:0] c);
        expOf = 0;
        foreach (ops[i])
            expOf += (ops[i][2:0] == c);
    endfunction
    task automatic endOfTest();
        $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input int got, input int exp);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic runTest(input string name);
        int n;
        {nIss, nLoad, nStore, nLimm, nPart, nHold} = '0;
        foreach (ops[i])
            feed.push(ops[i]);
        n = 0;
        while (feed.q.size() != 0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n == 400) begin
            chk(1, 0);
            endOfTest();
        end
        // drain: longest tail is three multiply parts plus two stages
        repeat (8) @(posedge clk);
        chk(nIss, ops.size() - expOf(`OP_LIMM) + 2 * expOf(`OP_MUL));
        chk(nLoad, expOf(`OP_LOAD));
        chk(nStore, expOf(`OP_STORE));
        chk(nLimm, expOf(`OP_LIMM));
        chk(nPart, 3 * expOf(`OP_MUL));
        chk(nHold, expOf(`OP_MUL));
        $display("test %s done", name);
        ops.delete();
    endtask
    initial begin
        logic [31:0] r;
        logic [2:0]  c;
        repeat (4) @(posedge clk);
        #1 srst = 1'b0;
        ops = '{op(`OP_MUL, 2'h0, 1'b0), op(`OP_ALU, 2'h0, 1'b0), op(`OP_LIMM, 2'h0, 1'b0),
            op(`OP_ALUX, 2'h0, 1'b0), op(`OP_ALU, 2'h2, 1'b0), op(`OP_ALU, 2'h0, 1'b0), op(`OP_ALU, 2'h0, 1'b0)};
        runTest("multiply mix");
        ops = '{op(`OP_LOAD, 2'h0, 1'b0), op(`OP_LOAD, 2'h0, 1'b0), op(`OP_LOAD, 2'h0, 1'b1),
            op(`OP_LOAD, 2'h0, 1'b0), op(`OP_ALU, 2'h3, 1'b0), op(`OP_STORE, 2'h0, 1'b0)};
        runTest("load burst");
        repeat (6) begin
            repeat (8) begin
                r = nextRand();
                c = r[2:0] % 3'h6;
                ops.push_back(op(c, r[9:8], (c == `OP_LOAD) & r[12]));
            end
            runTest("random");
        end
        endOfTest();
    end
endmodule
